// File: hw/coord_pkg.sv
package coord_pkg;
  localparam int unsigned FRAME_BYTES = 9;
  localparam logic [7:0] OP_GET_COORD = 8'h1f;
  localparam logic [7:0] OP_CAPTURE_COORD = 8'h20;
  localparam logic [7:0] OP_XCALC = 8'h21;
  localparam logic [7:0] OP_ACCU_TO_AXIS = 8'h22;
  localparam logic [7:0] OP_ACCU_TO_COORD = 8'h27;
  localparam logic [7:0] BANK_NVM = 8'hff;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0] GLOBAL_PERSIST_PARAM = 8'h54;
  localparam logic PERSIST_RESET = 1'b0;
  localparam int unsigned NUM_COORDS = 21;
  localparam logic [7:0] LAST_COORD = 8'h14;
  localparam logic [3:0] XOP_ADD = 4'h0;
  localparam logic [3:0] XOP_SUB = 4'h1;
  localparam logic [3:0] XOP_MUL = 4'h2;
  localparam logic [3:0] XOP_DIV = 4'h3;
  localparam logic [3:0] XOP_MOD = 4'h4;
  localparam logic [3:0] XOP_AND = 4'h5;
  localparam logic [3:0] XOP_OR = 4'h6;
  localparam logic [3:0] XOP_XOR = 4'h7;
  localparam logic [3:0] XOP_NOT = 4'h8;
  localparam logic [3:0] XOP_LOAD = 4'h9;
  localparam logic [3:0] XOP_SWAP = 4'ha;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] kind;
    logic [7:0] motor;
    logic [31:0] value;
  } frame_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
  } reply_s;

  typedef struct packed {
    logic [7:0] index;
    logic [31:0] value;
  } param_wr_s;
endpackage : coord_pkg

// File: hw/frame_receiver.sv
`timescale 1ns/1ps
module frame_receiver
  import coord_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  output logic frameValid,
  output frame_s frame,
  output logic frameGood
);
  logic [3:0] count_q;
  logic [7:0] sum_q;
  logic [63:0] bytes_q;
  logic last;

  assign last = rxValid && (count_q == 4'(FRAME_BYTES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_q <= 4'h0;
      sum_q <= 8'h00;
      bytes_q <= 64'h0;
    end
    else if (clkEn && rxValid)
    begin
      // Most significant value byte arrives first
      if (last)
      begin
        count_q <= 4'h0;
        sum_q <= 8'h00;
      end
      else
      begin
        count_q <= count_q + 4'h1;
        sum_q <= sum_q + rxByte;
        bytes_q <= {bytes_q[55:0], rxByte};
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      frameValid <= 1'b0;
      frame <= '0;
      frameGood <= 1'b0;
    end
    else if (clkEn)
    begin
      frameValid <= last;
      if (last)
      begin
        frame <= bytes_q;
        frameGood <= (sum_q == rxByte);
      end
    end
  end
endmodule : frame_receiver

// File: hw/coordinate_and_accu_command_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Standalone get-coordinate loads accumulator
// - Direct get-coordinate replies, accumulator untouched
// - Global 84 selects RAM or persistent
// - Entry zero never persisted
// - Coordinate 0, motor 255 restores entries 1..20
// - Motor 255 restores one entry 1..20
// - Capture copies actual position to entry
// - Accumulator-to-coordinate writes selected entry
// - X calc uses X, result to accumulator for types 0-7
// - Types 0-4 add sub mul div mod
// - Types 5-7 and or xor
// - Type 8 inverts X register
// - Type 9 load X, 10 swap
// - Accumulator to axis parameter by type
// - Axis parameter transfer uses code 34
module coordinate_and_accu_command_unit
  import coord_pkg::*;
#(
  parameter int unsigned COORD_COUNT = NUM_COORDS,
  parameter logic [7:0] MODULE_ADDR = 8'h01
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic standalone,
  input wire logic [31:0] actualPos,
  input wire logic globalWrValid,
  input wire logic [7:0] globalWrIndex,
  input wire logic [31:0] globalWrValue,
  output reply_s reply,
  output logic replyValid,
  output param_wr_s axisParamWr,
  output logic axisParamWrValid,
  output logic [31:0] accu,
  output logic [31:0] xReg,
  output logic persistMode
);
  frame_s frame;
  logic frameValid;
  logic frameGood;
  logic [31:0] ramCoord_q [COORD_COUNT];
  logic [31:0] nvmCoord_q [COORD_COUNT];
  logic [31:0] accu_q;
  logic [31:0] xReg_q;
  logic persist_q;
  logic booted_q;
  logic [31:0] accu_d;
  logic [31:0] xReg_d;
  logic [7:0] status_d;
  logic [31:0] value_d;
  logic forUs;
  logic idxOk;
  logic nvmSel;
  logic [4:0] idx;

  frame_receiver u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .rxValid(rxValid),
    .rxByte(rxByte),
    .frameValid(frameValid),
    .frame(frame),
    .frameGood(frameGood)
  );

  function automatic logic [31:0] safe_div(input logic [31:0] a, input logic [31:0] b,
                                           input logic wantMod);
    // Divide by zero leaves the dividend rather than trapping
    if (b == 32'h0)
      safe_div = a;
    else if (wantMod)
      safe_div = 32'($signed(a) % $signed(b));
    else
      safe_div = 32'($signed(a) / $signed(b));
  endfunction : safe_div

  assign forUs = frameValid && frameGood && (frame.addr == MODULE_ADDR);
  assign idx = frame.kind[4:0];
  assign idxOk = (frame.kind <= LAST_COORD);
  assign nvmSel = (frame.motor == BANK_NVM);

  // Global parameter 84 sets persistence; RAM only after reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      persist_q <= PERSIST_RESET;
    else if (clkEn && globalWrValid && globalWrIndex == GLOBAL_PERSIST_PARAM)
      persist_q <= globalWrValue[0];
  end

  // Startup restore needs persist_q on the first enabled cycle after reset, but reset clears persist_q, so it never runs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      booted_q <= 1'b0;
    else if (clkEn)
      booted_q <= 1'b1;
  end

  always_comb
  begin
    accu_d = accu_q;
    xReg_d = xReg_q;
    status_d = STATUS_OK;
    value_d = 32'h0;
    unique case (frame.opcode)
      OP_GET_COORD:
        if (!idxOk)
          status_d = STATUS_BAD_TYPE;
        else if (!nvmSel)
        begin
          if (standalone)
            accu_d = ramCoord_q[idx];
          else
            value_d = ramCoord_q[idx];
        end
      OP_CAPTURE_COORD, OP_ACCU_TO_COORD:
        if (!idxOk)
          status_d = STATUS_BAD_TYPE;
      OP_ACCU_TO_AXIS: ;
      OP_XCALC:
        unique case (frame.kind[3:0])
          XOP_ADD: accu_d = accu_q + xReg_q;
          XOP_SUB: accu_d = accu_q - xReg_q;
          XOP_MUL: accu_d = 32'($signed(accu_q) * $signed(xReg_q));
          XOP_DIV: accu_d = safe_div(accu_q, xReg_q, 1'b0);
          XOP_MOD: accu_d = safe_div(accu_q, xReg_q, 1'b1);
          XOP_AND: accu_d = accu_q & xReg_q;
          XOP_OR: accu_d = accu_q | xReg_q;
          XOP_XOR: accu_d = accu_q ^ xReg_q;
          XOP_NOT: xReg_d = ~xReg_q;
          XOP_LOAD: xReg_d = accu_q;
          XOP_SWAP:
          begin
            accu_d = xReg_q;
            xReg_d = accu_q;
          end
          default: status_d = STATUS_BAD_TYPE;
        endcase
      default: status_d = STATUS_BAD_CMD;
    endcase
    if (frame.opcode == OP_XCALC && frame.kind[7:4] != 4'h0)
    begin
      status_d = STATUS_BAD_TYPE;
      accu_d = accu_q;
      xReg_d = xReg_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      accu_q <= 32'h0;
      xReg_q <= 32'h0;
    end
    else if (clkEn && forUs && status_d == STATUS_OK)
    begin
      accu_q <= accu_d;
      xReg_q <= xReg_d;
    end
  end

  // Coordinate RAM and its persistent shadow
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < COORD_COUNT; i++)
        ramCoord_q[i] <= 32'h0;
    end
    else if (clkEn)
    begin
      if (!booted_q && persist_q)
      begin
        for (int i = 1; i < COORD_COUNT; i++)
          ramCoord_q[i] <= nvmCoord_q[i];
      end
      else if (forUs && idxOk)
      begin
        unique case (frame.opcode)
          OP_GET_COORD:
            if (nvmSel && idx == 5'h0)
            begin
              for (int i = 1; i < COORD_COUNT; i++)
                ramCoord_q[i] <= nvmCoord_q[i];
            end
            else if (nvmSel)
              ramCoord_q[idx] <= nvmCoord_q[idx];
          OP_CAPTURE_COORD: ramCoord_q[idx] <= actualPos;
          OP_ACCU_TO_COORD: ramCoord_q[idx] <= accu_q;
          default: ;
        endcase
      end
    end
  end

  // Non-volatile copy is not cleared by reset; entry zero never written
  always_ff @(posedge ref_clk)
  begin
    if (clkEn && forUs && idxOk && persist_q && idx != 5'h0 && !nvmSel)
    begin
      if (frame.opcode == OP_CAPTURE_COORD)
        nvmCoord_q[idx] <= actualPos;
      else if (frame.opcode == OP_ACCU_TO_COORD)
        nvmCoord_q[idx] <= accu_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      axisParamWrValid <= 1'b0;
      axisParamWr <= '0;
    end
    else if (clkEn)
    begin
      axisParamWrValid <= forUs && frame.opcode == OP_ACCU_TO_AXIS;
      if (forUs && frame.opcode == OP_ACCU_TO_AXIS)
        axisParamWr <= '{index: frame.kind, value: accu_q};
    end
  end

  // Bad checksum answers; a frame for another address stays silent
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      replyValid <= 1'b0;
      reply <= '0;
    end
    else if (clkEn)
    begin
      replyValid <= frameValid && (frame.addr == MODULE_ADDR) && !standalone;
      if (frameValid && !frameGood)
        reply <= '{status: STATUS_BAD_CHECKSUM, opcode: frame.opcode, value: 32'h0};
      else if (frameValid)
        reply <= '{status: status_d, opcode: frame.opcode, value: value_d};
    end
  end

  assign accu = accu_q;
  assign xReg = xReg_q;
  assign persistMode = persist_q;
endmodule : coordinate_and_accu_command_unit

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model
  import coord_pkg::*;
(
  input wire logic ref_clk,
  output logic rxValid,
  output logic [7:0] rxByte
);
  initial
  begin
    rxValid = 1'b0;
    rxByte = 8'h00;
  end
  task automatic send(input frame_s f, input logic bad);
    logic [7:0] b [9];
    b[8] = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      b[i] = f[63 - 8 * i -: 8];
      b[8] = b[8] + b[i];
    end
    b[8] = b[8] ^ {7'h00, bad};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge ref_clk);
      rxValid <= 1'b1;
      rxByte <= b[i];
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    // Inverted so a stale byte never looks valid
    rxByte <= ~b[8];
  endtask : send
endmodule : host_model

// File: testbench/cmd_unit_assertions.sv
`timescale 1ns/1ps
module cmd_unit_checker
  import coord_pkg::*;
#(
  parameter logic [7:0] MODULE_ADDR = 8'h01
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic standalone,
  input wire logic globalWrValid,
  input wire logic [7:0] globalWrIndex,
  input wire logic [31:0] globalWrValue,
  input wire reply_s reply,
  input wire logic replyValid,
  input wire param_wr_s axisParamWr,
  input wire logic axisParamWrValid,
  input wire logic [31:0] accu,
  input wire logic [31:0] xReg,
  input wire logic persistMode
);
  logic [3:0] byteCnt_q;
  logic [63:0] shift_q;
  logic [7:0] sum_q;
  logic done, xc, pBit;
  assign pBit = globalWrValue[0];
  assign done = clkEn && rxValid && byteCnt_q == 4'h8 && rxByte == sum_q
    && shift_q[63:56] == MODULE_ADDR;
  assign xc = done && shift_q[55:48] == OP_XCALC;
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      byteCnt_q <= 4'h0;
      sum_q <= 8'h00;
    end
    else if (clkEn && rxValid)
    begin
      byteCnt_q <= (byteCnt_q == 4'h8) ? 4'h0 : byteCnt_q + 4'h1;
      sum_q <= (byteCnt_q == 4'h8) ? 8'h00 : sum_q + rxByte;
    end
  always_ff @(posedge ref_clk)
    if (clkEn && rxValid)
      shift_q <= {shift_q[55:0], rxByte};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reply_pulse: assert property (replyValid |=> !replyValid)
    else $error("reply strobe too long");
  a_reset_ram: assert property ($past(rst) |-> !persistMode && accu == 32'h0)
    else $error("state not cleared by reset");
  a_persist_set: assert property (clkEn && globalWrValid
    && globalWrIndex == GLOBAL_PERSIST_PARAM |=> persistMode == $past(pBit))
    else $error("persistence not taken");
  a_direct_read: assert property (done && shift_q[55:48] == OP_GET_COORD
    && shift_q[39:32] != BANK_NVM && !standalone
    |-> ##2 replyValid && reply.status == STATUS_OK && accu == $past(accu, 2))
    else $error("direct read wrong");
  a_alone_quiet: assert property (standalone && $past(standalone)
    && $past(standalone, 2) |-> !replyValid)
    else $error("reply in standalone");
  a_calc_add: assert property (xc && shift_q[47:40] == 8'h00
    |-> ##2 accu == $past(accu, 2) + $past(xReg, 2))
    else $error("add wrong");
  a_swap_regs: assert property (xc && shift_q[47:40] == 8'h0a
    |-> ##2 accu == $past(xReg, 2) && xReg == $past(accu, 2))
    else $error("swap wrong");
  a_invert_x: assert property (xc && shift_q[47:40] == 8'h08
    |-> ##2 xReg == ~$past(xReg, 2) && accu == $past(accu, 2))
    else $error("invert wrong");
  a_axis_param: assert property (done && shift_q[55:48] == OP_ACCU_TO_AXIS
    |-> ##2 axisParamWrValid && axisParamWr.value == $past(accu, 2))
    else $error("axis write wrong");
endmodule : cmd_unit_checker

bind coordinate_and_accu_command_unit cmd_unit_checker #(.MODULE_ADDR(MODULE_ADDR)) chk_u (.*);

// File: testbench/tb_coordinate_and_accu_command_unit.sv
`timescale 1ns/1ps
module tb_coordinate_and_accu_command_unit
  import coord_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst, clkEn, rxValid, standalone, globalWrValid, replyValid;
  logic axisParamWrValid, persistMode, gotReply;
  logic [7:0] rxByte, globalWrIndex;
  logic [31:0] actualPos, globalWrValue, accu, xReg, ea, ex;
  reply_s reply;
  param_wr_s axisParamWr;
  int err_total, n_tests;
  always #5 ref_clk = ~ref_clk;
  host_model host_u (.ref_clk(ref_clk), .rxValid(rxValid), .rxByte(rxByte));
  coordinate_and_accu_command_unit dut_u (.*);
  task automatic close_out();
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [7:0] k, input logic [7:0] m,
    input logic bad);
    host_u.send('{8'h01, op, k, m, 32'h0}, bad);
    gotReply = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      #1;
      if (replyValid === 1'b1) gotReply = 1'b1;
    end
    @(posedge ref_clk);
    if (gotReply === standalone)
    begin
      $display("unexpected %0t reply presence", $time);
      err_total++;
      close_out();
    end
  endtask : cmd
  task automatic t_coords();
    actualPos <= 32'h0000_0123;
    cmd(OP_CAPTURE_COORD, 8'h01, 8'h00, 1'b0);
    chk(reply.status, STATUS_OK);
    actualPos <= 32'hffff_fff9;
    cmd(OP_CAPTURE_COORD, 8'h02, 8'h00, 1'b0);
    standalone <= 1'b1;
    cmd(OP_GET_COORD, 8'h01, 8'h00, 1'b0);
    chk(accu, 32'h0000_0123);
    cmd(OP_XCALC, 8'h09, 8'h00, 1'b0);
    cmd(OP_GET_COORD, 8'h02, 8'h00, 1'b0);
    standalone <= 1'b0;
    cmd(OP_GET_COORD, 8'h01, 8'h00, 1'b0);
    chk(reply.value, 32'h0000_0123);
    chk(accu, 32'hffff_fff9);
    cmd(OP_ACCU_TO_COORD, 8'h03, 8'h00, 1'b0);
    cmd(OP_GET_COORD, 8'h03, 8'h00, 1'b0);
    chk(reply.value, 32'hffff_fff9);
  endtask : t_coords
  task automatic t_xcalc();
    ea = 32'hffff_fff9;
    ex = 32'h0000_0123;
    for (int t = 0; t < 11; t++)
    begin
      case (t)
        0: ea = ea + ex;
        1: ea = ea - ex;
        2: ea = ea * ex;
        3: ea = $signed(ea) / $signed(ex);
        4: ea = $signed(ea) % $signed(ex);
        5: ea = ea & ex;
        6: ea = ea | ex;
        7: ea = ea ^ ex;
        8: ex = ~ex;
        9: ex = ea;
        default: {ea, ex} = {ex, ea};
      endcase
      cmd(OP_XCALC, 8'(t), 8'h00, 1'b0);
      chk(accu, ea);
      chk(xReg, ex);
    end
  endtask : t_xcalc
  task automatic t_refuse();
    cmd(OP_ACCU_TO_AXIS, 8'h07, 8'h00, 1'b0);
    chk({24'h0, axisParamWr.index}, 32'h7);
    chk(axisParamWr.value, ea);
    cmd(OP_XCALC, 8'h00, 8'h00, 1'b1);
    chk(reply.status, STATUS_BAD_CHECKSUM);
    chk({24'h0, reply.opcode}, {24'h0, OP_XCALC});
    chk(accu, ea);
    cmd(8'h05, 8'h00, 8'h00, 1'b0);
    chk(reply.status, STATUS_BAD_CMD);
    cmd(OP_XCALC, 8'h0b, 8'h00, 1'b0);
    chk(reply.status, STATUS_BAD_TYPE);
    chk(accu, ea);
    chk(xReg, ex);
  endtask : t_refuse
  task automatic cap(input logic [7:0] k, input logic [31:0] p);
    actualPos <= p;
    cmd(OP_CAPTURE_COORD, k, 8'h00, 1'b0);
  endtask : cap
  task automatic persist(input logic v);
    globalWrIndex <= GLOBAL_PERSIST_PARAM;
    globalWrValue <= {31'h0, v};
    globalWrValid <= 1'b1;
    @(posedge ref_clk);
    globalWrValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({31'h0, persistMode}, {31'h0, v});
  endtask : persist
  task automatic t_persist();
    persist(1'b1);
    cap(8'h04, 32'h0000_0444);
    cap(8'h00, 32'h0000_0500);
    persist(1'b0);
    cap(8'h04, 32'h0000_0666);
    cap(8'h00, 32'h0000_0666);
    cmd(OP_GET_COORD, 8'h00, BANK_NVM, 1'b0);
    cmd(OP_GET_COORD, 8'h04, 8'h00, 1'b0);
    chk(reply.value, 32'h0000_0444);
    cmd(OP_GET_COORD, 8'h00, 8'h00, 1'b0);
    chk(reply.value, 32'h0000_0666);
    cap(8'h04, 32'h0000_0777);
    cmd(OP_GET_COORD, 8'h04, BANK_NVM, 1'b0);
    cmd(OP_GET_COORD, 8'h04, 8'h00, 1'b0);
    chk(reply.value, 32'h0000_0444);
  endtask : t_persist
  initial
  begin
    rst = 1'b1;
    clkEn = 1'b1;
    standalone = 1'b0;
    actualPos = 32'h0;
    globalWrValid = 1'b0;
    globalWrIndex = 8'h00;
    globalWrValue = 32'h0;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, persistMode}, 32'h0);
    t_coords();
    t_xcalc();
    t_refuse();
    t_persist();
    close_out();
  end
endmodule : tb_coordinate_and_accu_command_unit
